// ===== hw/anp_next_page_regs.v
// Contract
// - In SGMII mode the transmit next page word is 16 bits of plain read/write user storage.
// - In SGMII mode the partner next page word is 16 bits of user storage with no fixed meaning.
// - In 1000BASE-X mode bit 15 of the transmit page is writable and flags more pages to follow.
// - Bit 14 of the transmit page is reserved acknowledge; software writes zero, reads mean nothing.
// - Writable bit 13 of the transmit page marks a message page (1) or unformatted page (0).
// - Writable bit 12 of the transmit page advertises that the local side can comply.
// - Transmit toggle bit 11 is made by hardware: inverse of the last exchanged toggle, first from base bit 11.
// - Writable bits 10:0 of the transmit page carry the message or unformatted code.
// - Read-only bit 15 of the partner page reports whether the partner has more pages.
// - Read-only bit 13 of the partner page shows a partner message page.
// - Read-only bit 12 of the partner page shows the partner can comply.
// - Read-only bits 10:0 of the partner page show the partner code exactly as received.
// - Storing a partner page sets a page-received flag in expansion bit 1, cleared by reading it.
`timescale 1ns/1ps
`default_nettype none
`include "anp_defs.vh"
module anp_next_page_regs (
  input wire CORE_CLK,
  input wire NRST,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire RX_PAGE_VALID,
  input wire [15:0] RX_PAGE_WORD,
  input wire TX_PAGE_SENT,
  input wire AUTONEG_RESTART,
  output reg [15:0] TX_PAGE_WORD,
  output reg SGMII_MODE,
  output reg IRQ
);
  // --------------------------------------------------------------------------
  // Input synchronisers for the link-side event strobes
  // --------------------------------------------------------------------------
  reg rx_valid_s1_reg;
  reg rx_valid_s2_reg;
  reg rx_valid_s3_reg;
  reg sent_s1_reg;
  reg sent_s2_reg;
  reg sent_s3_reg;
  reg restart_s1_reg;
  reg restart_s2_reg;
  reg [15:0] rx_word_s1_reg;
  reg [15:0] rx_word_s2_reg;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_valid_s1_reg <= 1'b0;
      rx_valid_s2_reg <= 1'b0;
      rx_valid_s3_reg <= 1'b0;
      sent_s1_reg <= 1'b0;
      sent_s2_reg <= 1'b0;
      sent_s3_reg <= 1'b0;
      restart_s1_reg <= 1'b0;
      restart_s2_reg <= 1'b0;
      rx_word_s1_reg <= 16'h0000;
      rx_word_s2_reg <= 16'h0000;
    end else begin
      rx_valid_s1_reg <= RX_PAGE_VALID;
      rx_valid_s2_reg <= rx_valid_s1_reg;
      rx_valid_s3_reg <= rx_valid_s2_reg;
      sent_s1_reg <= TX_PAGE_SENT;
      sent_s2_reg <= sent_s1_reg;
      sent_s3_reg <= sent_s2_reg;
      restart_s1_reg <= AUTONEG_RESTART;
      restart_s2_reg <= restart_s1_reg;
      rx_word_s1_reg <= RX_PAGE_WORD;
      rx_word_s2_reg <= rx_word_s1_reg;
    end
  end
  // Word must be stable before the valid level rises; rising edge stores it
  wire rx_store = rx_valid_s2_reg & ~rx_valid_s3_reg;
  wire tx_sent = sent_s2_reg & ~sent_s3_reg;
  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Accesses take two cycles: waitrequest drops one edge after the request
  reg busy_reg;
  wire req = (AVS_READ | AVS_WRITE) & ~busy_reg;
  wire [3:0] idx = AVS_ADDRESS[5:2];
  wire wr_lo = AVS_WRITE & req & AVS_BYTEENABLE[0];
  wire wr_hi = AVS_WRITE & req & AVS_BYTEENABLE[1];
  wire [15:0] be_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire wr_any = AVS_WRITE & req;
  wire rd_go = AVS_READ & req;
  wire hit_tx = (idx == `ANP_IDX_NP_TX);
  wire hit_rx = (idx == `ANP_IDX_NP_RX);
  wire hit_cfg = (idx == `ANP_IDX_CONFIG);
  wire hit_clr = (idx == `ANP_IDX_IRQ_CLEAR);
  wire hit_en = (idx == `ANP_IDX_IRQ_ENABLE);
  wire hit_base = (idx == `ANP_IDX_BASE_PAGE);
  wire hit_exp = (idx == `ANP_IDX_EXPANSION);
  // --------------------------------------------------------------------------
  // Mode, base page and toggle tracking
  // --------------------------------------------------------------------------
  reg sgmii_reg;
  reg [15:0] base_page_reg;
  reg first_page_reg;
  reg toggle_reg;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sgmii_reg <= 1'b0;
      base_page_reg <= `ANP_RST_BASE_PAGE;
    end else begin
      if (wr_lo && hit_cfg) begin
        sgmii_reg <= AVS_WRITEDATA[`ANP_CFG_SGMII];
      end
      if (wr_any && hit_base) begin
        base_page_reg <= (AVS_WRITEDATA[15:0] & be_mask) | (base_page_reg & ~be_mask);
      end
    end
  end
  // Toggle follows each page exchanged; restart rearms from base page bit 11
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      first_page_reg <= 1'b1;
      toggle_reg <= 1'b0;
    end else if (restart_s2_reg) begin
      first_page_reg <= 1'b1;
    end else if (tx_sent) begin
      first_page_reg <= 1'b0;
      toggle_reg <= first_page_reg ? ~base_page_reg[`ANP_BIT_TOGGLE] : ~toggle_reg;
    end
  end
  wire toggle_now = first_page_reg ? ~base_page_reg[`ANP_BIT_TOGGLE] : ~toggle_reg;
  // --------------------------------------------------------------------------
  // Page storage
  // --------------------------------------------------------------------------
  // In 1000BASE-X the ack and toggle positions are not writable
  wire [15:0] tx_mask = be_mask & (sgmii_reg ? 16'hffff : `ANP_NP_TX_WR_MASK);
  wire [15:0] tx_store;
  wire [15:0] rx_store_word;
  anp_page_store #(.WIDTH(16), .RESET_VALUE(`ANP_RST_NP_TX)) u_tx_page (
    .clk(CORE_CLK),
    .nrst(NRST),
    .wr_en(wr_any && hit_tx),
    .wr_mask(tx_mask),
    .wr_data(AVS_WRITEDATA[15:0]),
    .rd_data(tx_store)
  );
  // SGMII mode: software may write the partner word as user storage
  wire rx_sw_wr = wr_any & hit_rx & sgmii_reg;
  anp_page_store #(.WIDTH(16), .RESET_VALUE(`ANP_RST_NP_RX)) u_rx_page (
    .clk(CORE_CLK),
    .nrst(NRST),
    .wr_en(rx_store | rx_sw_wr),
    .wr_mask(rx_store ? 16'hffff : be_mask),
    .wr_data(rx_store ? rx_word_s2_reg : AVS_WRITEDATA[15:0]),
    .rd_data(rx_store_word)
  );
  // Ack bit reads zero in 1000BASE-X; software ignores it either way
  wire [15:0] tx_view = sgmii_reg ? tx_store :
    {tx_store[15], 1'b0, tx_store[13:12], toggle_now, tx_store[10:0]};
  wire [15:0] rx_view = sgmii_reg ? rx_store_word : (rx_store_word & `ANP_CODE_MASK);
  // --------------------------------------------------------------------------
  // Page-received flag and interrupts
  // --------------------------------------------------------------------------
  reg page_rcvd_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_enable_reg;
  wire rd_exp = rd_go & hit_exp;
  // A new page in the same cycle as the clearing read stays set
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      page_rcvd_reg <= 1'b0;
    end else if (rx_store) begin
      page_rcvd_reg <= 1'b1;
    end else if (rd_exp) begin
      page_rcvd_reg <= 1'b0;
    end
  end
  wire [1:0] irq_set = {tx_sent, rx_store};
  wire [1:0] irq_clr = (wr_lo && hit_clr) ? AVS_WRITEDATA[1:0] : 2'h0;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_status_reg <= 2'h0;
      irq_enable_reg <= 2'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      if (wr_lo && hit_en) begin
        irq_enable_reg <= AVS_WRITEDATA[1:0];
      end
    end
  end
  // --------------------------------------------------------------------------
  // Read mux and bus handshake
  // --------------------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    case (idx)
      `ANP_IDX_EXPANSION: rd_mux = {13'h0000, 1'b1, page_rcvd_reg, 1'b0};
      `ANP_IDX_NP_TX: rd_mux = tx_view;
      `ANP_IDX_NP_RX: rd_mux = rx_view;
      `ANP_IDX_CONFIG: rd_mux = {15'h0000, sgmii_reg};
      `ANP_IDX_IRQ_STATUS: rd_mux = {14'h0000, irq_status_reg};
      `ANP_IDX_IRQ_ENABLE: rd_mux = {14'h0000, irq_enable_reg};
      `ANP_IDX_BASE_PAGE: rd_mux = base_page_reg;
      default: rd_mux = 16'h0000;
    endcase
  end
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      busy_reg <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      TX_PAGE_WORD <= 16'h0000;
      SGMII_MODE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      busy_reg <= req;
      AVS_WAITREQUEST <= ~req;
      if (rd_go) begin
        AVS_READDATA <= {16'h0000, rd_mux};
      end
      TX_PAGE_WORD <= tx_view;
      SGMII_MODE <= sgmii_reg;
      IRQ <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_enable_reg);
    end
  end
endmodule // anp_next_page_regs
`default_nettype wire

// ===== hw/anp_defs.vh
`ifndef ANP_DEFS_VH
`define ANP_DEFS_VH
// ----------------------------------------------------------------------------
// Register offsets (printed indices; byte address is four times the index)
// ----------------------------------------------------------------------------
`define ANP_IDX_EXPANSION 4'h6
`define ANP_IDX_NP_TX 4'h7
`define ANP_IDX_NP_RX 4'h8
`define ANP_IDX_CONFIG 4'h9
`define ANP_IDX_IRQ_STATUS 4'ha
`define ANP_IDX_IRQ_CLEAR 4'hb
`define ANP_IDX_IRQ_ENABLE 4'hc
`define ANP_IDX_BASE_PAGE 4'hd
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ANP_BIT_MORE_PAGES 15
`define ANP_BIT_ACK 14
`define ANP_BIT_MESSAGE 13
`define ANP_BIT_COMPLY 12
`define ANP_BIT_TOGGLE 11
`define ANP_BIT_PAGE_RCVD 1
`define ANP_BIT_NP_ABLE 2
`define ANP_CFG_SGMII 0
// Interrupt status layout
`define ANP_IRQ_PAGE_RCVD 0
`define ANP_IRQ_PAGE_SENT 1
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ANP_RST_NP_TX 16'h0000
`define ANP_RST_NP_RX 16'h0000
`define ANP_RST_BASE_PAGE 16'h0000
`define ANP_CODE_MASK 16'hbfff
// Writable transmit bits in 1000BASE-X: 15, 13, 12 and 10:0
`define ANP_NP_TX_WR_MASK 16'hb7ff
`endif

// ===== hw/anp_page_store.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Page storage word with registered read data
// ----------------------------------------------------------------------------
module anp_page_store #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire nrst,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_mask,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] word_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          word_reg[i] <= RESET_VALUE[i];
        end else if (wr_en && wr_mask[i]) begin
          word_reg[i] <= wr_data[i];
        end
      end
    end
  endgenerate
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= RESET_VALUE;
    end else begin
      rd_data <= word_reg;
    end
  end
endmodule // anp_page_store
`default_nettype wire

// ===== test/anp_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Remote link partner: pages and exchange events
// ----
module anp_partner (
  input wire logic clk,
  output logic valid,
  output logic [15:0] word,
  output logic sent
);
  initial begin
    valid = 1'b0;
    word = 16'h0000;
    sent = 1'b0;
  end
  // Word is set up well ahead of valid; once released it shows junk
  task send_page(input logic [15:0] w);
    word <= w;
    repeat (4) @(posedge clk);
    valid <= 1'b1;
    repeat (4) @(posedge clk);
    valid <= 1'b0;
    word <= ~w;
    repeat (5) @(posedge clk);
  endtask
  task page_sent();
    sent <= 1'b1;
    repeat (4) @(posedge clk);
    sent <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule // anp_partner
`default_nettype wire

// ===== test/anp_next_page_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module anp_next_page_regs_properties (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic TX_PAGE_SENT,
  input wire logic AUTONEG_RESTART,
  input wire logic [15:0] TX_PAGE_WORD,
  input wire logic SGMII_MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_wait_one: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST
    |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_rdata_upper: assert property (AVS_READDATA[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_tx_ack_zero: assert property (!SGMII_MODE && !$past(SGMII_MODE) && !$past(SGMII_MODE, 2)
    |-> !TX_PAGE_WORD[14])
    else $error("reserved ack bit set in transmit page");
  a_toggle_flips: assert property ($rose(TX_PAGE_SENT) && !SGMII_MODE && !AUTONEG_RESTART
    |-> ##[1:5] $changed(TX_PAGE_WORD[11]))
    else $error("toggle did not flip after exchange");
  a_mode_cause: assert property ($changed(SGMII_MODE)
    |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
    else $error("mode changed without a write");
  a_mode_quiet: assert property (!AVS_WRITE && !$past(AVS_WRITE) |=> $stable(SGMII_MODE))
    else $error("mode moved while bus idle");
endmodule // anp_next_page_regs_properties
bind anp_next_page_regs anp_next_page_regs_properties i_chk (.CORE_CLK, .NRST, .AVS_READ,
  .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .TX_PAGE_SENT, .AUTONEG_RESTART,
  .TX_PAGE_WORD, .SGMII_MODE);
`default_nettype wire

// ===== test/anp_next_page_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module anp_next_page_regs_test;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, restart = 1'b0, valid, sent, irq, mode;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] word, txw, q;
  logic waitreq;
  int num_errors = 0, checked = 0;
  always #50 clk = ~clk;
  anp_partner i_lp (.clk(clk), .valid(valid), .word(word), .sent(sent));
  anp_next_page_regs i_dut (.CORE_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RX_PAGE_VALID(valid), .RX_PAGE_WORD(word),
    .TX_PAGE_SENT(sent), .AUTONEG_RESTART(restart), .TX_PAGE_WORD(txw),
    .SGMII_MODE(mode), .IRQ(irq));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it
  task bus(input logic w, input logic [3:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    chk(q, e);
  endtask
  task give_verdict();
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_tx_fields();
    rchk(4'h7, 16'h0800);
    bus(1'b1, 4'h7, 16'hffff);
    rchk(4'h7, 16'hbfff);
    repeat (2) @(posedge clk);
    chk(txw, 16'hbfff);
    bus(1'b1, 4'h7, 16'h4000);
    rchk(4'h7, 16'h0800);
    bus(1'b1, 4'hd, 16'h0800);
    rchk(4'h7, 16'h0000);
    i_lp.page_sent();
    rchk(4'h7, 16'h0800);
    restart <= 1'b1;
    repeat (5) @(posedge clk);
    restart <= 1'b0;
    rchk(4'h7, 16'h0000);
  endtask
  task t_rx_page();
    i_lp.send_page(16'hd5a5);
    rchk(4'h8, 16'h95a5);
    chk({15'h0, irq}, 16'h0000);
    // The earlier exchange in the transmit scenario left the page-sent status set
    rchk(4'ha, 16'h0003);
    bus(1'b1, 4'hc, 16'h0001);
    repeat (3) @(posedge clk);
    chk({15'h0, irq}, 16'h0001);
    rchk(4'h6, 16'h0006);
    rchk(4'h6, 16'h0004);
    bus(1'b1, 4'hb, 16'h0001);
    repeat (3) @(posedge clk);
    chk({15'h0, irq}, 16'h0000);
    rchk(4'ha, 16'h0002);
  endtask
  task t_sgmii();
    bus(1'b1, 4'h9, 16'h0001);
    repeat (2) @(posedge clk);
    chk({15'h0, mode}, 16'h0001);
    bus(1'b1, 4'h7, 16'h4c33);
    rchk(4'h7, 16'h4c33);
    bus(1'b1, 4'h8, 16'h1234);
    rchk(4'h8, 16'h1234);
    i_lp.send_page(16'h6ac3);
    rchk(4'h8, 16'h6ac3);
    bus(1'b1, 4'hf, 16'hffff);
    rchk(4'hf, 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(4'h8, 16'h0000);
    t_tx_fields();
    t_rx_page();
    t_sgmii();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule // anp_next_page_regs_test
`default_nettype wire
